// >>> core/e1tc_timeslot_ctrl.sv
`timescale 1ns/100ps

module e1tc_timeslot_ctrl
  import e1tc_pkg::*;
#(
  parameter longint ONE_SEC_CYCLES = e1tc_pkg::ONE_SECOND_CYC,
  parameter int     SLOTS          = 32
) (
  input  wire logic       clock,
  input  wire logic       rst,
  // Microprocessor port: page register value plus five address lines
  input  wire logic [4:0] busPage,
  input  wire logic [4:0] busAddr,
  input  wire logic [7:0] busWrData,
  input  wire logic       busWrEn,
  input  wire logic       busRdEn,
  output logic      [7:0] busRdData,
  // Global test sequence choice: one selects milliwatt, zero selects PRBS
  input  wire logic       test_sequence_select,
  // Slot stream, one byte per slot strobe
  input  wire logic       slotStrobe,
  input  wire logic [4:0] slotIndex,
  input  wire logic [7:0] backplane_data_in,
  input  wire logic [7:0] lineRxData,
  output logic      [7:0] lineTxData,
  output logic      [7:0] backplane_data_out,
  output logic            slotOutValid,
  // PRBS checker status
  output logic            prbsErrorPulse,
  output logic            prbsInSync,
  // Error events from the framer, one-cycle pulses
  input  wire logic       ebitErrorEvent,
  input  wire logic       fasErrorEvent,
  input  wire logic       bipolarViolEvent,
  input  wire logic       crc4ErrorEvent,
  output logic            oneSecondTick
);

  import e1tc_pkg::*;

  generate
    if (SLOTS != 32 || ONE_SEC_CYCLES < 2 || ONE_SEC_CYCLES > 64'h0000_0001_0000_0000)
    begin : g_bad
      $error("e1tc_timeslot_ctrl: SLOTS must be 32 and ONE_SEC_CYCLES from 2 to 2**32");
    end
  endgenerate

  // ==========================================================================
  // Register decode
  // ==========================================================================
  wire logic       inWindow    = busAddr >= SLOT_WINDOW_BASE;
  wire logic [4:0] windowSlot  = {busPage == PAGE_SLOT_CTRL_HI || busPage == PAGE_TX_MSG_HI,
                                  busAddr[3:0]};
  wire logic       hitCtrl     = inWindow &&
                                 (busPage == PAGE_SLOT_CTRL_LO || busPage == PAGE_SLOT_CTRL_HI);
  wire logic       hitMsg      = inWindow &&
                                 (busPage == PAGE_TX_MSG_LO || busPage == PAGE_TX_MSG_HI);
  wire logic       hitOneSec   = busPage == PAGE_ONE_SECOND;

  logic [7:0] ctrlWord_r [SLOTS];
  logic [7:0] msgBuf_r   [SLOTS];

  // one control word per slot, page picks the half
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
        ctrlWord_r[i] <= CTRL_RESET;
    end
    else if (busWrEn && hitCtrl)
    begin
      ctrlWord_r[windowSlot] <= busWrData & CTRL_WRITE_MASK;
    end
  end

  // Message buffer cleared on reset so an early message slot sends a known byte
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < SLOTS; i++)
        msgBuf_r[i] <= 8'h00;
    end
    else if (busWrEn && hitMsg)
    begin
      msgBuf_r[windowSlot] <= busWrData;
    end
  end

  // ==========================================================================
  // Running error counters and one-second latches
  // ==========================================================================
  logic [31:0]           secCount_r;
  logic                  secTick_r;
  logic [EBIT_WIDTH-1:0] ebitRun_r;
  logic [FAS_WIDTH-1:0]  fasRun_r;
  logic [BPV_WIDTH-1:0]  bpvRun_r;
  logic [CRC_WIDTH-1:0]  crcRun_r;
  logic [EBIT_WIDTH-1:0] latched_ebit_errors;
  logic [FAS_WIDTH-1:0]  latched_fas_errors;
  logic [BPV_WIDTH-1:0]  latched_bipolar_violations;
  logic [CRC_WIDTH-1:0]  latched_crc4_errors;

  wire logic [31:0] secLast = 32'(ONE_SEC_CYCLES - 1);
  wire logic        secWrap = secCount_r == secLast;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      secCount_r <= 32'h0000_0000;
      secTick_r  <= 1'b0;
    end
    else
    begin
      secCount_r <= secWrap ? 32'h0000_0000 : secCount_r + 32'h0000_0001;
      secTick_r  <= secWrap;
    end
  end

  assign oneSecondTick = secTick_r;

  // Counters saturate rather than wrap so a burst never reads as a small count.
  // On the tick the counter restarts, and an event in that same cycle counts as one.
  function automatic logic [15:0] runNext(
    input logic [15:0] cur,
    input logic [15:0] maxVal,
    input logic        ev,
    input logic        restart
  );
    logic [15:0] base;
    base = restart ? COUNT_RESET : cur;
    if (ev && base != maxVal)
      runNext = base + 16'h0001;
    else
      runNext = base;
  endfunction

  wire logic [15:0] ebitNxt = runNext(16'(ebitRun_r), 16'h03FF, ebitErrorEvent, secTick_r);
  wire logic [15:0] fasNxt  = runNext(16'(fasRun_r), 16'h00FF, fasErrorEvent, secTick_r);
  wire logic [15:0] bpvNxt  = runNext(bpvRun_r, 16'hFFFF, bipolarViolEvent, secTick_r);
  wire logic [15:0] crcNxt  = runNext(16'(crcRun_r), 16'h03FF, crc4ErrorEvent, secTick_r);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ebitRun_r <= COUNT_RESET[EBIT_WIDTH-1:0];
      fasRun_r  <= COUNT_RESET[FAS_WIDTH-1:0];
      bpvRun_r  <= COUNT_RESET[BPV_WIDTH-1:0];
      crcRun_r  <= COUNT_RESET[CRC_WIDTH-1:0];
    end
    else
    begin
      ebitRun_r <= ebitNxt[EBIT_WIDTH-1:0];
      fasRun_r  <= fasNxt[FAS_WIDTH-1:0];
      bpvRun_r  <= bpvNxt[BPV_WIDTH-1:0];
      crcRun_r  <= crcNxt[CRC_WIDTH-1:0];
    end
  end

  // Latches move only on the tick, so software reads a whole interval's count
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      latched_ebit_errors        <= COUNT_RESET[EBIT_WIDTH-1:0];
      latched_fas_errors         <= COUNT_RESET[FAS_WIDTH-1:0];
      latched_bipolar_violations <= COUNT_RESET[BPV_WIDTH-1:0];
      latched_crc4_errors        <= COUNT_RESET[CRC_WIDTH-1:0];
    end
    else if (secTick_r)
    begin
      latched_ebit_errors        <= ebitRun_r;
      latched_fas_errors         <= fasRun_r;
      latched_bipolar_violations <= bpvRun_r;
      latched_crc4_errors        <= crcRun_r;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [7:0] oneSecData;

  always_comb
  begin
    case (busAddr)
      OFS_EBIT_HIGH: oneSecData = {6'h00, latched_ebit_errors[9:8]};
      OFS_EBIT_LOW:  oneSecData = latched_ebit_errors[7:0];
      OFS_FAS:       oneSecData = latched_fas_errors;
      OFS_BPV_HIGH:  oneSecData = latched_bipolar_violations[15:8];
      OFS_BPV_LOW:   oneSecData = latched_bipolar_violations[7:0];
      OFS_CRC_HIGH:  oneSecData = {6'h00, latched_crc4_errors[9:8]};
      OFS_CRC_LOW:   oneSecData = latched_crc4_errors[7:0];
      default:       oneSecData = 8'h00;
    endcase
  end

  wire logic [7:0] rdSelect = hitCtrl   ? ctrlWord_r[windowSlot] :
                              hitMsg    ? msgBuf_r[windowSlot] :
                              hitOneSec ? oneSecData : 8'h00;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      busRdData <= 8'h00;
    else if (busRdEn)
      busRdData <= rdSelect;
  end

  // ==========================================================================
  // Test signal sources
  // ==========================================================================
  logic [14:0] genState_r;
  logic [14:0] chkState_r;
  logic [2:0]  mwPhase_r;
  wire  logic [14:0] genStateNxt;
  wire  logic [7:0]  genByte;
  wire  logic [14:0] chkStateUnused;
  wire  logic [7:0]  chkExpect;

  e1tc_prbs_step #(
    .WIDTH (PRBS_WIDTH),
    .BITS  (8)
  ) u_gen (
    .stateIn  (genState_r),
    .stateOut (genStateNxt),
    .bitsOut  (genByte)
  );

  e1tc_prbs_step #(
    .WIDTH (PRBS_WIDTH),
    .BITS  (8)
  ) u_chk (
    .stateIn  (chkState_r),
    .stateOut (chkStateUnused),
    .bitsOut  (chkExpect)
  );

  wire logic [7:0] slotCtrl  = ctrlWord_r[slotIndex];
  wire logic       selMsg    = slotCtrl[BIT_TX_MESSAGE_SELECT];
  wire logic       selInvert = slotCtrl[BIT_ALT_DIGIT_INVERT];
  wire logic       selRemote = slotCtrl[BIT_REMOTE_SLOT_LOOP];
  wire logic       selLocal  = slotCtrl[BIT_LOCAL_SLOT_LOOP];
  wire logic       selTxTest = slotCtrl[BIT_TX_TEST_ENABLE];
  wire logic       selRxTest = slotCtrl[BIT_RX_TEST_ENABLE];

  // Milliwatt sample advances once per frame, so every test slot of a frame
  // carries the same sample of the tone
  wire logic [7:0] mwByte   = MW_TABLE[63 - 8*mwPhase_r -: 8];
  wire logic       genUse   = slotStrobe && selTxTest && !test_sequence_select;
  wire logic       chkUse   = slotStrobe && selRxTest && !test_sequence_select;
  wire logic       frameEnd = slotStrobe && slotIndex == 5'(SLOTS - 1);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      genState_r <= PRBS_SEED;
      mwPhase_r  <= 3'h0;
    end
    else
    begin
      if (genUse)
        genState_r <= genStateNxt;
      if (frameEnd)
        mwPhase_r <= mwPhase_r + 3'h1;
    end
  end

  // ==========================================================================
  // Slot data paths
  // ==========================================================================
  // Inversion applies to backplane transmit data and the received line byte
  wire logic [7:0] invMask  = selInvert ? INVERT_PATTERN : 8'h00;
  wire logic [7:0] bpTxInv  = backplane_data_in ^ invMask;
  wire logic [7:0] rxInv    = lineRxData ^ invMask;
  wire logic [7:0] txSource = selMsg ? msgBuf_r[slotIndex] : bpTxInv;
  wire logic [7:0] txTest   = test_sequence_select ? mwByte : genByte;
  wire logic [7:0] txWithTest = selTxTest ? txTest : txSource;
  // Remote loopback returns the line byte untouched by inversion
  wire logic [7:0] txFinal  = selRemote ? lineRxData : txWithTest;
  wire logic [7:0] rxLooped = selLocal ? txFinal : rxInv;
  wire logic [7:0] rxFinal  = (selRxTest && test_sequence_select) ? mwByte : rxLooped;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lineTxData         <= 8'h00;
      backplane_data_out <= 8'h00;
      slotOutValid       <= 1'b0;
    end
    else
    begin
      slotOutValid <= slotStrobe;
      if (slotStrobe)
      begin
        lineTxData         <= txFinal;
        backplane_data_out <= rxFinal;
      end
    end
  end

  // ==========================================================================
  // PRBS checker
  // ==========================================================================
  // Self-synchronising: the register is refilled from the received bits, so
  // after two clean slot bytes the prediction tracks the far generator.
  // The trade is that each line bit error shows up as up to three mismatches.
  wire logic [7:0] chkDiff  = rxLooped ^ chkExpect;
  wire logic       chkMatch = chkDiff == 8'h00;
  logic [1:0]      chkFill_r;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      chkState_r     <= PRBS_SEED;
      chkFill_r      <= 2'h0;
      prbsErrorPulse <= 1'b0;
      prbsInSync     <= 1'b0;
    end
    else
    begin
      prbsErrorPulse <= 1'b0;
      if (chkUse)
      begin
        chkState_r <= {chkState_r[6:0], rxLooped};
        if (chkFill_r != 2'h2)
          chkFill_r <= chkFill_r + 2'h1;
        else
        begin
          prbsErrorPulse <= !chkMatch;
          prbsInSync     <= chkMatch;
        end
      end
    end
  end

endmodule

// >>> pkg/e1tc_pkg.sv
package e1tc_pkg;

  // ==========================================================================
  // Register pages and offsets
  // ==========================================================================
  localparam logic [4:0] PAGE_SLOT_CTRL_LO = 5'h07;
  localparam logic [4:0] PAGE_SLOT_CTRL_HI = 5'h08;
  localparam logic [4:0] PAGE_ONE_SECOND   = 5'h09;
  localparam logic [4:0] PAGE_TX_MSG_LO    = 5'h0F;
  localparam logic [4:0] PAGE_TX_MSG_HI    = 5'h10;

  // Per slot words sit at 10H..1FH of their page
  localparam logic [4:0] SLOT_WINDOW_BASE = 5'h10;

  localparam logic [4:0] OFS_EBIT_HIGH = 5'h10;
  localparam logic [4:0] OFS_EBIT_LOW  = 5'h11;
  localparam logic [4:0] OFS_FAS       = 5'h12;
  localparam logic [4:0] OFS_BPV_HIGH  = 5'h13;
  localparam logic [4:0] OFS_BPV_LOW   = 5'h14;
  localparam logic [4:0] OFS_CRC_HIGH  = 5'h15;
  localparam logic [4:0] OFS_CRC_LOW   = 5'h16;

  // ==========================================================================
  // Control word fields
  // ==========================================================================
  localparam int BIT_TX_MESSAGE_SELECT   = 7;
  localparam int BIT_ALT_DIGIT_INVERT    = 6;
  localparam int BIT_REMOTE_SLOT_LOOP    = 5;
  localparam int BIT_LOCAL_SLOT_LOOP     = 4;
  localparam int BIT_TX_TEST_ENABLE      = 3;
  localparam int BIT_RX_TEST_ENABLE      = 2;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hFC;
  localparam logic [7:0] CTRL_RESET      = 8'h00;

  // ==========================================================================
  // Counter widths and reset values
  // ==========================================================================
  localparam int EBIT_WIDTH = 10;
  localparam int FAS_WIDTH  = 8;
  localparam int BPV_WIDTH  = 16;
  localparam int CRC_WIDTH  = 10;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==========================================================================
  // Channel data constants
  // ==========================================================================
  // Every second bit of a slot byte is inverted
  localparam logic [7:0] INVERT_PATTERN = 8'h55;
  localparam int         PRBS_WIDTH  = 15;
  localparam logic [14:0] PRBS_SEED  = 15'h7FFF;
  localparam int         MW_LENGTH   = 8;
  // A-law digital milliwatt, one period of eight samples
  localparam logic [63:0] MW_TABLE = 64'h3421_2134_B4A1_A1B4;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint CLOCK_HZ       = 100000000;
  localparam longint ONE_SECOND_NS  = 1000000000;
  localparam longint ONE_SECOND_CYC = (ONE_SECOND_NS * CLOCK_HZ) / 1000000000;

endpackage

// >>> core/e1tc_prbs_step.sv
`timescale 1ns/100ps

// ============================================================================
// One byte of a 2^15-1 sequence (x^15 + x^14 + 1), first bit in the MSB
// ============================================================================
module e1tc_prbs_step #(
  parameter int WIDTH = 15,
  parameter int BITS  = 8
) (
  input  wire logic [WIDTH-1:0] stateIn,
  output logic      [WIDTH-1:0] stateOut,
  output logic      [BITS-1:0]  bitsOut
);

  generate
    if (WIDTH < 15 || BITS > WIDTH)
    begin : g_bad
      $error("e1tc_prbs_step: unsupported WIDTH or BITS");
    end
  endgenerate

  always_comb
  begin
    logic [WIDTH-1:0] s;
    logic             fb;
    s = stateIn;
    fb = 1'b0;
    bitsOut = '0;
    for (int i = 0; i < BITS; i++)
    begin
      fb = s[14] ^ s[13];
      bitsOut[BITS-1-i] = fb;
      s = {s[WIDTH-2:0], fb};
    end
    stateOut = s;
  end

endmodule

// >>> testbench/e1tc_timeslot_ctrl_props.sv
`timescale 1ns/100ps

// ====================
// Port-level checks on slot control, slot data paths and the one-second tick
module e1tc_timeslot_ctrl_props
  import e1tc_pkg::*;
#(
  parameter int ONE_SEC_CYCLES = 50
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [4:0] busPage,
  input wire logic [4:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic       busWrEn,
  input wire logic       busRdEn,
  input wire logic [7:0] busRdData,
  input wire logic       test_sequence_select,
  input wire logic       slotStrobe,
  input wire logic [4:0] slotIndex,
  input wire logic [7:0] backplane_data_in,
  input wire logic [7:0] lineRxData,
  input wire logic [7:0] lineTxData,
  input wire logic [7:0] backplane_data_out,
  input wire logic       slotOutValid,
  input wire logic       prbsInSync,
  input wire logic       oneSecondTick
);
  // Shadow words come from bus writes only, so a stuck design register shows up
  logic [7:0] shadow [32];
  wire       ctrlPage = busPage == PAGE_SLOT_CTRL_LO || busPage == PAGE_SLOT_CTRL_HI;
  wire       ctrlHit  = ctrlPage && busAddr[4];
  wire [4:0] busSlot  = {busPage == PAGE_SLOT_CTRL_HI, busAddr[3:0]};
  wire [7:0] rdExp    = shadow[busSlot];
  wire [7:0] cw       = shadow[slotIndex];
  wire [7:0] invMask  = cw[6] ? INVERT_PATTERN : 8'h00;
  wire [7:0] txPlain  = backplane_data_in ^ invMask;
  wire [7:0] rxPlain  = lineRxData ^ invMask;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      shadow <= '{default: CTRL_RESET};
    else if (busWrEn && ctrlHit)
      shadow[busSlot] <= busWrData & CTRL_WRITE_MASK;
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ====================
  // Assertions
  ctrl_read_a: assert property (busRdEn && ctrlHit |=> busRdData == $past(rdExp))
    else $error("control word read mismatch");
  unmapped_read_a: assert property (busRdEn && busPage == PAGE_ONE_SECOND
    && busAddr > OFS_CRC_LOW |=> busRdData == 8'h00) else $error("unused latch not zero");
  pass_through_a: assert property (slotStrobe && !cw[7] && !cw[5] && !cw[3]
    |=> lineTxData == $past(txPlain)) else $error("transmit byte mismatch");
  remote_loop_a: assert property (slotStrobe && cw[5] && !cw[4] && !cw[2]
    |=> lineTxData == $past(lineRxData) && backplane_data_out == $past(rxPlain))
    else $error("remote loop mismatch");
  local_loop_a: assert property (slotStrobe && cw[4] && !cw[2]
    |=> backplane_data_out == lineTxData) else $error("local loop mismatch");
  rx_plain_a: assert property (slotStrobe && !cw[4] && !cw[2]
    |=> backplane_data_out == $past(rxPlain)) else $error("receive byte mismatch");
  tx_test_a: assert property (slotStrobe && cw[3] && !cw[5] && test_sequence_select
    |=> lineTxData inside {8'h34, 8'h21, 8'hB4, 8'hA1}) else $error("milliwatt missing");
  valid_pulse_a: assert property (slotOutValid == $past(slotStrobe))
    else $error("slot valid not one cycle after strobe");
  tick_period_a: assert property (oneSecondTick |-> ##ONE_SEC_CYCLES oneSecondTick)
    else $error("sampling period wrong");
  tick_gap_a: assert property (oneSecondTick |=> !oneSecondTick [*8])
    else $error("sampling tick too long");

  cover property (slotStrobe && cw[5]);
  cover property ($rose(prbsInSync));
  cover property (oneSecondTick);
endmodule

bind e1tc_timeslot_ctrl e1tc_timeslot_ctrl_props #(.ONE_SEC_CYCLES(ONE_SEC_CYCLES)) u_props (
  .clock(clock), .rst(rst), .busPage(busPage), .busAddr(busAddr), .busWrData(busWrData),
  .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
  .test_sequence_select(test_sequence_select), .slotStrobe(slotStrobe),
  .slotIndex(slotIndex), .backplane_data_in(backplane_data_in), .lineRxData(lineRxData),
  .lineTxData(lineTxData), .backplane_data_out(backplane_data_out),
  .slotOutValid(slotOutValid), .prbsInSync(prbsInSync), .oneSecondTick(oneSecondTick));

// >>> testbench/e1tc_stream_src.sv
`timescale 1ns/100ps

// ====================
// Far side of the slot stream: backplane and line byte sources
module e1tc_stream_src (
  input  wire logic       clock,
  output logic            slotStrobe,
  output logic      [4:0] slotIndex,
  output logic      [7:0] backplane_data_in,
  output logic      [7:0] lineRxData
);
  initial
  begin
    slotStrobe = 1'b0;
    slotIndex = 5'h00;
    backplane_data_in = 8'h00;
    lineRxData = 8'h00;
  end

  // Outside a slot the bytes are stale, so show their inverse rather than hold them
  task automatic send(input logic [4:0] idx, input logic [7:0] bp, input logic [7:0] rx);
    @(posedge clock);
    slotStrobe <= 1'b1;
    slotIndex <= idx;
    backplane_data_in <= bp;
    lineRxData <= rx;
    @(posedge clock);
    slotStrobe <= 1'b0;
    slotIndex <= ~idx;
    backplane_data_in <= ~bp;
    lineRxData <= ~rx;
  endtask
endmodule

// >>> testbench/e1tc_timeslot_ctrl_tb.sv
`timescale 1ns/100ps

// ====================
// Bench for slot control words and one-second latches
module e1tc_timeslot_ctrl_tb;
  import e1tc_pkg::*;
  localparam longint SEC = 50;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [4:0] busPage = 5'h00;
  logic [4:0] busAddr = 5'h00;
  logic [7:0] busWrData = 8'h00;
  logic       busWrEn = 1'b0;
  logic       busRdEn = 1'b0;
  logic       test_sequence_select = 1'b0;
  logic       ebitErrorEvent = 1'b0;
  logic       fasErrorEvent = 1'b0;
  logic       bipolarViolEvent = 1'b0;
  logic       crc4ErrorEvent = 1'b0;
  logic       slotStrobe, slotOutValid, prbsErrorPulse, prbsInSync, oneSecondTick;
  logic [4:0] slotIndex;
  logic [7:0] backplane_data_in, lineRxData, lineTxData, backplane_data_out, busRdData;
  logic [7:0] prev = 8'h00;
  logic       errSeen = 1'b0;
  logic [7:0] latchExp [7] = '{8'h00, 8'h05, 8'h03, 8'h00, 8'h02, 8'h00, 8'h01};
  int         errors = 0;
  int         checksDone = 0;

  always #5 clock = ~clock;
  always @(posedge clock)
    if (prbsErrorPulse === 1'b1)
      errSeen <= 1'b1;

  e1tc_stream_src u_src (.clock(clock), .slotStrobe(slotStrobe), .slotIndex(slotIndex),
    .backplane_data_in(backplane_data_in), .lineRxData(lineRxData));

  e1tc_timeslot_ctrl #(.ONE_SEC_CYCLES(SEC)) u_dut (.clock(clock), .rst(rst),
    .busPage(busPage), .busAddr(busAddr), .busWrData(busWrData), .busWrEn(busWrEn),
    .busRdEn(busRdEn), .busRdData(busRdData), .test_sequence_select(test_sequence_select),
    .slotStrobe(slotStrobe), .slotIndex(slotIndex), .backplane_data_in(backplane_data_in),
    .lineRxData(lineRxData), .lineTxData(lineTxData), .backplane_data_out(backplane_data_out),
    .slotOutValid(slotOutValid), .prbsErrorPulse(prbsErrorPulse), .prbsInSync(prbsInSync),
    .ebitErrorEvent(ebitErrorEvent), .fasErrorEvent(fasErrorEvent),
    .bipolarViolEvent(bipolarViolEvent), .crc4ErrorEvent(crc4ErrorEvent),
    .oneSecondTick(oneSecondTick));

  // ====================
  // Compare, bus and stream tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [4:0] pg, input logic [4:0] ad, input logic [7:0] d);
    @(posedge clock);
    busPage <= pg;
    busAddr <= ad;
    busWrData <= d;
    busWrEn <= 1'b1;
    @(posedge clock);
    busWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] pg, input logic [4:0] ad, input logic [7:0] exp);
    @(posedge clock);
    busPage <= pg;
    busAddr <= ad;
    busRdEn <= 1'b1;
    @(posedge clock);
    busRdEn <= 1'b0;
    #1;
    chk8(busRdData, exp);
  endtask

  task automatic tx(input logic [4:0] idx, input logic [7:0] bp, input logic [7:0] rx,
                    input logic [7:0] expTx, input logic [7:0] expOut);
    u_src.send(idx, bp, rx);
    #1;
    chk1(slotOutValid, 1'b1);
    chk8(lineTxData, expTx);
    chk8(backplane_data_out, expOut);
  endtask

  task automatic waitTick();
    @(posedge clock);
    #1;
    for (int i = 0; i < SEC && oneSecondTick !== 1'b1; i++)
    begin
      @(posedge clock);
      #1;
    end
    chk1(oneSecondTick, 1'b1);
  endtask

  task automatic giveVerdict();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ====================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(PAGE_SLOT_CTRL_HI, 5'h1F, CTRL_RESET);
    wr(PAGE_SLOT_CTRL_LO, 5'h13, 8'h43);
    wr(PAGE_SLOT_CTRL_HI, 5'h13, 8'hFF);
    rd(PAGE_SLOT_CTRL_LO, 5'h13, 8'h40);
    rd(PAGE_SLOT_CTRL_HI, 5'h13, 8'hFC);
    wr(PAGE_ONE_SECOND, OFS_FAS, 8'hFF);
    rd(PAGE_ONE_SECOND, OFS_FAS, 8'h00);
    rd(PAGE_ONE_SECOND, 5'h17, 8'h00);
    tx(5'd3, 8'h0F, 8'hF0, 8'h5A, 8'hA5);
    tx(5'd9, 8'h0F, 8'hF0, 8'h0F, 8'hF0);
    wr(PAGE_SLOT_CTRL_LO, 5'h14, 8'h20);
    tx(5'd4, 8'h11, 8'h3C, 8'h3C, 8'h3C);
    wr(PAGE_SLOT_CTRL_LO, 5'h18, 8'h10);
    tx(5'd8, 8'h66, 8'h00, 8'h66, 8'h66);
    @(posedge clock);
    test_sequence_select <= 1'b1;
    wr(PAGE_SLOT_CTRL_HI, 5'h14, 8'h08);
    wr(PAGE_SLOT_CTRL_HI, 5'h15, 8'h08);
    wr(PAGE_SLOT_CTRL_LO, 5'h16, 8'h04);
    tx(5'd20, 8'h00, 8'h00, MW_TABLE[63:56], 8'h00);
    tx(5'd21, 8'h00, 8'h00, MW_TABLE[63:56], 8'h00);
    tx(5'd22, 8'h77, 8'h00, 8'h77, 8'h00);
    tx(5'd6, 8'h00, 8'h00, 8'h00, MW_TABLE[63:56]);
    tx(5'd31, 8'h00, 8'h00, 8'h00, 8'h00);
    tx(5'd20, 8'h00, 8'h00, MW_TABLE[55:48], 8'h00);
    wr(PAGE_TX_MSG_HI, 5'h1F, 8'hC3);
    wr(PAGE_TX_MSG_LO, 5'h1F, 8'h3C);
    rd(PAGE_TX_MSG_HI, 5'h1F, 8'hC3);
    rd(PAGE_TX_MSG_LO, 5'h1F, 8'h3C);
    wr(PAGE_SLOT_CTRL_HI, 5'h1F, 8'h80);
    tx(5'd31, 8'h12, 8'h00, 8'hC3, 8'h00);
    // Prime with one generated byte so the checker never sees a false history
    @(posedge clock);
    test_sequence_select <= 1'b0;
    wr(PAGE_SLOT_CTRL_LO, 5'h17, 8'h08);
    u_src.send(5'd7, 8'h00, 8'h00);
    #1;
    prev = lineTxData;
    // All-ones seed yields eight zeros as the first generated byte
    chk8(prev, 8'h00);
    wr(PAGE_SLOT_CTRL_LO, 5'h17, 8'h0C);
    for (int i = 0; i < 8; i++)
    begin
      u_src.send(5'd7, 8'h00, prev);
      #1;
      prev = lineTxData;
    end
    chk1(prbsInSync, 1'b1);
    chk1(errSeen, 1'b0);
    u_src.send(5'd7, 8'h00, prev ^ 8'h10);
    repeat (3) @(posedge clock);
    #1;
    chk1(errSeen, 1'b1);
    waitTick();
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clock);
      ebitErrorEvent <= (i < 5);
      fasErrorEvent <= (i < 3);
      bipolarViolEvent <= (i < 2);
      crc4ErrorEvent <= (i < 1);
    end
    waitTick();
    for (int i = 0; i < 7; i++)
      rd(PAGE_ONE_SECOND, OFS_EBIT_HIGH + 5'(i), latchExp[i]);
    repeat (10) @(posedge clock);
    rd(PAGE_ONE_SECOND, OFS_EBIT_LOW, 8'h05);
    waitTick();
    rd(PAGE_ONE_SECOND, OFS_EBIT_LOW, 8'h00);
    giveVerdict();
  end

  initial
  begin
    #50000;
    errors++;
    giveVerdict();
  end
endmodule
